/* File: src/pps_port.sv */
// Parallel port with composite status register, strobe lines and bus register file.
//
// Behaviour
// - Read-only status holds three individual flags
// - Summary follows flags gated by enables
// - Summary clear when all enabled flags clear
// - Timer flag clears on reset or initialisation
// - Counter read clears after status read
// - Status bits three to six read zero
// - Direction bit one drives pin out
// - Data writes change only output bits
// - Input bits live or latched by strobe
// - Port reset clears data, direction, strobe flags
// - Port reset set by reset, cleared by zero
// - Strobe edge sets first strobe flag except during port reset
// - Strobe flag clears on data access after status read
// - Edge select: zero falling, one rising
// - Latch captures once, data read re-arms
// - Second line input sets second strobe flag
// - Plain output mode drives control bit
// - Handshake pulse low for one bus phase
// - Acknowledge high on flag, low after clear
// - Control bit six has no function
// - Address lines select registers directly
`timescale 1ns/1ps
`default_nettype none
`include "pps_defines.svh"

module pps_port #(
	parameter int WIDTH = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ext_reset_n,
	input wire logic bus_phase,
	input wire logic bus_sel,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic [2:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	output logic irq_n,
	input wire logic [WIDTH-1:0] port_pins_in,
	output logic [WIDTH-1:0] port_pins_out,
	output logic [WIDTH-1:0] port_pins_oe,
	input wire logic strobe_in_line,
	input wire logic strobe_io_line_in,
	output logic strobe_io_line_out,
	output logic strobe_io_line_oe,
	input wire logic timer_flag_set,
	input wire logic timer_irq_en,
	input wire logic timer_soft_reset,
	input wire logic timer_counter_init,
	input wire logic timer_latch_write,
	input wire logic interval_mode_sel,
	input wire logic timer_counter_read
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0] port_control_reg; // Port control register
	logic [WIDTH-1:0] pin_direction_reg; // Per-pin direction
	logic [WIDTH-1:0] port_out_reg; // Output data bits
	logic [WIDTH-1:0] latch_reg; // Strobe-captured inputs
	logic latch_full_reg; // Latch holds data not yet read
	logic timer_flag_reg; // Timer flag
	logic strobe1_flag_reg; // First strobe flag
	logic strobe2_flag_reg; // Second strobe flag
	logic timer_seen_reg; // Status read saw timer flag set
	logic strobe1_seen_reg; // Status read saw strobe1 flag set
	logic strobe2_seen_reg; // Status read saw strobe2 flag set
	logic line2_out_reg; // Second line output level
	logic pulse_pending_reg; // Handshake pulse requested
	logic pulse_low_reg; // Handshake pulse in progress
	logic phase_d_reg; // Bus phase delayed
	logic [7:0] bus_rdata_reg; // Registered read data
	logic [2:0] rst_sync_reg; // External reset synchroniser
	logic [2:0] s1_sync_reg; // Strobe input synchroniser
	logic [2:0] s2_sync_reg; // Second line synchroniser
	logic [2:0] ph_sync_reg; // Bus phase synchroniser
	logic [WIDTH-1:0] pin_sync1_reg; // Pin synchroniser stage one
	logic [WIDTH-1:0] pin_sync2_reg; // Pin synchroniser stage two
	logic [WIDTH-1:0] pin_sync3_reg; // Pin synchroniser stage three
	logic [WIDTH-1:0] pin_live_reg; // Agreed pin levels
	logic ext_rst_active; // External reset asserted
	logic port_reset; // Port held in reset
	logic s1_level_reg; // Agreed strobe input level
	logic s2_level_reg; // Agreed second line level
	logic ph_level_reg; // Agreed bus phase level
	logic s1_edge; // Active edge on strobe input
	logic s2_edge; // Active edge on second line
	logic phase_rise; // Rising edge of the bus phase
	logic access_rd; // Bus read this cycle
	logic access_wr; // Bus write this cycle
	logic status_rd; // Read of the status register
	logic value_access; // Read or write of data register
	logic value_rd; // Read of data register
	logic summary; // Summary interrupt
	logic timer_clear; // Timer flag clear this cycle
	logic strobe1_clear; // First strobe flag clear
	logic strobe2_clear; // Second strobe flag clear
	logic [7:0] status_byte; // Assembled status value
	logic [WIDTH-1:0] input_view; // Input bits seen by the bus
	pps_pkg::pps_l2_mode_t l2_mode; // Second line behaviour

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Active edge detector chosen by an edge select bit
	function automatic logic edge_hit(input logic now, input logic prev, input logic rising);
		edge_hit = rising ? (now & ~prev) : (~now & prev);
	endfunction : edge_hit

	// Second line behaviour from the direction, mode and control bits
	function automatic pps_pkg::pps_l2_mode_t l2_decode(input logic [7:0] pc);
		if (!pc[`PPS_PC_L2_DIR]) begin
			l2_decode = pps_pkg::pps_l2_input;
		end else if (pc[`PPS_PC_L2_MODE]) begin
			l2_decode = pps_pkg::pps_l2_plain;
		end else if (pc[`PPS_PC_L2_CTL]) begin
			l2_decode = pps_pkg::pps_l2_handshake;
		end else begin
			l2_decode = pps_pkg::pps_l2_irq_ack;
		end
	endfunction : l2_decode

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Three stages per line; a level is accepted when stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rst_sync_reg <= 3'h7;
			s1_sync_reg <= 3'h0;
			s2_sync_reg <= 3'h0;
			ph_sync_reg <= 3'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[1:0], ext_reset_n};
			s1_sync_reg <= {s1_sync_reg[1:0], strobe_in_line};
			s2_sync_reg <= {s2_sync_reg[1:0], strobe_io_line_in};
			ph_sync_reg <= {ph_sync_reg[1:0], bus_phase};
		end
	end

	// Agreed levels of the control lines
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s1_level_reg <= 1'b0;
			s2_level_reg <= 1'b0;
			ph_level_reg <= 1'b0;
		end else begin
			if (s1_sync_reg[1] == s1_sync_reg[2]) begin
				s1_level_reg <= s1_sync_reg[2];
			end
			if (s2_sync_reg[1] == s2_sync_reg[2]) begin
				s2_level_reg <= s2_sync_reg[2];
			end
			if (ph_sync_reg[1] == ph_sync_reg[2]) begin
				ph_level_reg <= ph_sync_reg[2];
			end
		end
	end

	// Port pins, one generate slice per bit
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_pin
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					pin_sync1_reg[gi] <= 1'b0;
					pin_sync2_reg[gi] <= 1'b0;
					pin_sync3_reg[gi] <= 1'b0;
					pin_live_reg[gi] <= 1'b0;
				end else begin
					pin_sync1_reg[gi] <= port_pins_in[gi];
					pin_sync2_reg[gi] <= pin_sync1_reg[gi];
					pin_sync3_reg[gi] <= pin_sync2_reg[gi];
					if (pin_sync2_reg[gi] == pin_sync3_reg[gi]) begin
						pin_live_reg[gi] <= pin_sync3_reg[gi];
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Edge detection and access decode
	// ----------------------------------------------------------------
	// Previous levels for edge detection
	logic s1_prev_reg;
	logic s2_prev_reg;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s1_prev_reg <= 1'b0;
			s2_prev_reg <= 1'b0;
			phase_d_reg <= 1'b0;
		end else begin
			s1_prev_reg <= s1_level_reg;
			s2_prev_reg <= s2_level_reg;
			phase_d_reg <= ph_level_reg;
		end
	end

	assign ext_rst_active = ~rst_sync_reg[2] & ~rst_sync_reg[1];
	assign port_reset = port_control_reg[`PPS_PC_PORT_RESET];
	assign s1_edge = edge_hit(s1_level_reg, s1_prev_reg, port_control_reg[`PPS_PC_S1_EDGE]);
	assign s2_edge = edge_hit(s2_level_reg, s2_prev_reg, port_control_reg[`PPS_PC_L2_MODE]);
	assign phase_rise = ph_level_reg & ~phase_d_reg;
	assign access_rd = bus_sel & bus_rd;
	assign access_wr = bus_sel & bus_wr;
	assign l2_mode = l2_decode(port_control_reg);

	// Address decode, two status addresses
	always_comb begin
		status_rd = 1'b0;
		value_access = 1'b0;
		if (bus_addr == `PPS_ADDR_STATUS || bus_addr == `PPS_ADDR_STATUS_ALIAS) begin
			status_rd = access_rd;
		end else if (bus_addr == `PPS_ADDR_VALUE) begin
			value_access = access_rd | access_wr;
		end
	end
	assign value_rd = access_rd && bus_addr == `PPS_ADDR_VALUE;

	// ----------------------------------------------------------------
	// Port control register
	// ----------------------------------------------------------------
	// Reset bit set by external reset or a one, cleared only by a zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			port_control_reg <= `PPS_CONTROL_RESET;
		end else begin
			if (access_wr && bus_addr == `PPS_ADDR_CONTROL) begin
				port_control_reg <= bus_wdata;
			end
			if (ext_rst_active) begin
				port_control_reg[`PPS_PC_PORT_RESET] <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Direction and output data
	// ----------------------------------------------------------------
	// Direction writes take effect only while the port is out of reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst || port_reset) begin
			pin_direction_reg <= '0;
		end else if (access_wr && bus_addr == `PPS_ADDR_DIRECTION) begin
			pin_direction_reg <= bus_wdata[WIDTH-1:0];
		end
	end

	// Only bits of output pins take the written value
	always_ff @(posedge clk_sys) begin
		if (sys_rst || port_reset) begin
			port_out_reg <= '0;
		end else if (access_wr && bus_addr == `PPS_ADDR_VALUE) begin
			port_out_reg <= (bus_wdata[WIDTH-1:0] & pin_direction_reg)
				| (port_out_reg & ~pin_direction_reg);
		end
	end

	assign port_pins_out = port_out_reg & pin_direction_reg;
	assign port_pins_oe = pin_direction_reg;

	// ----------------------------------------------------------------
	// Input latch
	// ----------------------------------------------------------------
	// First edge captures, a data read re-arms
	always_ff @(posedge clk_sys) begin
		if (sys_rst || port_reset || !port_control_reg[`PPS_PC_LATCH_EN]) begin
			latch_full_reg <= 1'b0;
			latch_reg <= '0;
		end else if (value_rd) begin
			latch_full_reg <= 1'b0;
		end else if (s1_edge && !latch_full_reg) begin
			latch_reg <= pin_live_reg;
			latch_full_reg <= 1'b1;
		end
	end

	// Live or latched view of input bits
	assign input_view = (port_control_reg[`PPS_PC_LATCH_EN] && latch_full_reg)
		? latch_reg : pin_live_reg;

	// ----------------------------------------------------------------
	// Interrupt flags
	// ----------------------------------------------------------------
	assign timer_clear = timer_soft_reset | ext_rst_active | timer_counter_init
		| (timer_latch_write & interval_mode_sel)
		| (timer_counter_read & timer_seen_reg);
	assign strobe1_clear = value_access & strobe1_seen_reg;
	assign strobe2_clear = value_access & strobe2_seen_reg;

	// Timer flag, set wins over clear
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			timer_flag_reg <= 1'b0;
		end else if (timer_flag_set) begin
			timer_flag_reg <= 1'b1;
		end else if (timer_clear) begin
			timer_flag_reg <= 1'b0;
		end
	end

	// Strobe flags; port reset holds them clear
	always_ff @(posedge clk_sys) begin
		if (sys_rst || port_reset) begin
			strobe1_flag_reg <= 1'b0;
			strobe2_flag_reg <= 1'b0;
		end else begin
			if (s1_edge) begin
				strobe1_flag_reg <= 1'b1;
			end else if (strobe1_clear) begin
				strobe1_flag_reg <= 1'b0;
			end
			if (s2_edge && l2_mode == pps_pkg::pps_l2_input) begin
				strobe2_flag_reg <= 1'b1;
			end else if (strobe2_clear) begin
				strobe2_flag_reg <= 1'b0;
			end
		end
	end

	// Record that a status read saw each flag set
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			timer_seen_reg <= 1'b0;
			strobe1_seen_reg <= 1'b0;
			strobe2_seen_reg <= 1'b0;
		end else begin
			if (status_rd && timer_flag_reg) begin
				timer_seen_reg <= 1'b1;
			end else if (timer_clear || !timer_flag_reg) begin
				timer_seen_reg <= 1'b0;
			end
			if (status_rd && strobe1_flag_reg) begin
				strobe1_seen_reg <= 1'b1;
			end else if (strobe1_clear || !strobe1_flag_reg) begin
				strobe1_seen_reg <= 1'b0;
			end
			if (status_rd && strobe2_flag_reg) begin
				strobe2_seen_reg <= 1'b1;
			end else if (strobe2_clear || !strobe2_flag_reg) begin
				strobe2_seen_reg <= 1'b0;
			end
		end
	end

	// Summary is a pure function of flags and enables, order independent
	assign summary = (timer_flag_reg & timer_irq_en)
		| (strobe1_flag_reg & port_control_reg[`PPS_PC_S1_IRQ_EN])
		| (strobe2_flag_reg & port_control_reg[`PPS_PC_L2_CTL]
			& ~port_control_reg[`PPS_PC_L2_DIR]);
	assign irq_n = ~summary;
	assign status_byte = {summary, 4'h0, strobe2_flag_reg, strobe1_flag_reg,
		timer_flag_reg};

	// ----------------------------------------------------------------
	// Second control line output
	// ----------------------------------------------------------------
	// Handshake pulse request from a data register access
	always_ff @(posedge clk_sys) begin
		if (sys_rst || port_reset || l2_mode != pps_pkg::pps_l2_handshake) begin
			pulse_pending_reg <= 1'b0;
			pulse_low_reg <= 1'b0;
		end else if (value_access) begin
			pulse_pending_reg <= 1'b1;
		end else if (phase_rise) begin
			pulse_low_reg <= pulse_pending_reg;
			pulse_pending_reg <= 1'b0;
		end
	end

	// Line level per mode
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			line2_out_reg <= 1'b1;
		end else begin
			case (l2_mode)
				pps_pkg::pps_l2_plain: begin
					line2_out_reg <= port_control_reg[`PPS_PC_L2_CTL];
				end
				pps_pkg::pps_l2_handshake: begin
					line2_out_reg <= ~pulse_low_reg;
				end
				pps_pkg::pps_l2_irq_ack: begin
					if (strobe1_flag_reg) begin
						line2_out_reg <= 1'b1;
					end else if (phase_rise) begin
						line2_out_reg <= 1'b0;
					end
				end
				default: begin
					line2_out_reg <= 1'b1;
				end
			endcase
		end
	end

	assign strobe_io_line_out = line2_out_reg;
	assign strobe_io_line_oe = (l2_mode != pps_pkg::pps_l2_input);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Registered read mux; timer addresses read zero here
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			bus_rdata_reg <= `PPS_BYTE_ZERO;
		end else if (access_rd) begin
			if (bus_addr == `PPS_ADDR_STATUS || bus_addr == `PPS_ADDR_STATUS_ALIAS) begin
				bus_rdata_reg <= status_byte;
			end else if (bus_addr == `PPS_ADDR_CONTROL) begin
				bus_rdata_reg <= port_control_reg;
			end else if (bus_addr == `PPS_ADDR_DIRECTION) begin
				bus_rdata_reg <= 8'(pin_direction_reg);
			end else if (bus_addr == `PPS_ADDR_VALUE) begin
				bus_rdata_reg <= 8'((port_out_reg & pin_direction_reg)
					| (input_view & ~pin_direction_reg));
			end else begin
				bus_rdata_reg <= `PPS_BYTE_ZERO;
			end
		end
	end
	assign bus_rdata = bus_rdata_reg;

endmodule : pps_port
`default_nettype wire

/* File: inc/pps_defines.svh */
// Register offsets, field positions and reset values of the parallel port.
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets on the three address lines
// ----------------------------------------------------------------
`define PPS_ADDR_STATUS 3'h0
`define PPS_ADDR_CONTROL 3'h1
`define PPS_ADDR_DIRECTION 3'h2
`define PPS_ADDR_VALUE 3'h3
`define PPS_ADDR_STATUS_ALIAS 3'h4
`define PPS_ADDR_TIMER_CTRL 3'h5
`define PPS_ADDR_TIMER_HIGH 3'h6
`define PPS_ADDR_TIMER_LOW 3'h7

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define PPS_ST_TIMER 0
`define PPS_ST_STROBE1 1
`define PPS_ST_STROBE2 2
`define PPS_ST_SUMMARY 7

// ----------------------------------------------------------------
// Port control register fields
// ----------------------------------------------------------------
`define PPS_PC_S1_IRQ_EN 0
`define PPS_PC_S1_EDGE 1
`define PPS_PC_LATCH_EN 2
`define PPS_PC_L2_CTL 3
`define PPS_PC_L2_MODE 4
`define PPS_PC_L2_DIR 5
`define PPS_PC_PORT_RESET 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PPS_CONTROL_RESET 8'h80
`define PPS_BYTE_ZERO 8'h00

`endif

/* File: inc/pps_pkg.sv */
// Types shared by the parallel port design.
package pps_pkg;

	// Output behaviour of the second control line
	typedef enum logic [1:0] {
		pps_l2_input,
		pps_l2_plain,
		pps_l2_handshake,
		pps_l2_irq_ack
	} pps_l2_mode_t;

endpackage : pps_pkg

/* File: tb/pps_port_asserts.sv */
// Checker of the parallel port's bus, pin and interrupt behaviour.
`timescale 1ns/1ps
`default_nettype none

module pps_port_chk #(
	parameter int WIDTH = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ext_reset_n,
	input wire logic bus_sel,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic [2:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata,
	input wire logic irq_n,
	input wire logic [WIDTH-1:0] port_pins_oe,
	input wire logic strobe_io_line_out,
	input wire logic strobe_io_line_oe,
	input wire logic timer_flag_set,
	input wire logic timer_irq_en,
	input wire logic timer_soft_reset,
	input wire logic timer_counter_init,
	input wire logic timer_latch_write,
	input wire logic timer_counter_read
);
	logic [2:0] ext_hi_reg; // Cycles since external reset released
	logic rd_st; // Status read at either address
	logic wr_ctl; // Control register write
	logic l2_dir; // Line two direction bit of the write data
	logic tmr_keep; // Timer interrupt enabled and no clear event
	assign rd_st = bus_sel && bus_rd && bus_addr[1:0] == 2'h0;
	assign wr_ctl = bus_sel && bus_wr && bus_addr == 3'h1;
	assign l2_dir = bus_wdata[5];
	assign tmr_keep = timer_irq_en && !timer_soft_reset && !timer_counter_init
		&& !timer_latch_write && !timer_counter_read && ext_reset_n;
	// Saturating count so the synchroniser delay of the reset pin is skipped
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !ext_reset_n) begin
			ext_hi_reg <= 3'h0;
		end else if (ext_hi_reg != 3'h7) begin
			ext_hi_reg <= ext_hi_reg + 3'h1;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	status_pad_a: assert property (rd_st |=> bus_rdata[6:3] == 4'h0)
		else $error("status padding bits not zero");
	summary_irq_a: assert property (rd_st |=> bus_rdata[7] == !$past(irq_n))
		else $error("summary bit disagrees with interrupt line");
	timer_regs_a: assert property (bus_sel && bus_rd && bus_addr >= 3'h5 |=> bus_rdata == 8'h00)
		else $error("timer address read not zero");
	dir_readback_a: assert property (bus_sel && bus_rd && bus_addr == 3'h2 && ext_hi_reg == 3'h7
		|=> bus_rdata == $past(port_pins_oe))
		else $error("direction readback differs from pin enables");
	port_clear_a: assert property (wr_ctl && bus_wdata[7] |=> ##1 port_pins_oe == '0)
		else $error("port reset left pins driven");
	ext_clear_a: assert property (!ext_reset_n [*8] |-> port_pins_oe == '0)
		else $error("external reset left pins driven");
	line2_dir_a: assert property (wr_ctl |=> strobe_io_line_oe == $past(l2_dir))
		else $error("line two enable not from direction bit");
	plain_high_a: assert property (wr_ctl && bus_wdata[5:3] == 3'h7 |-> ##[1:3] strobe_io_line_out)
		else $error("plain output not high");
	plain_low_a: assert property (wr_ctl && bus_wdata[5:3] == 3'h6 |-> ##[1:3] !strobe_io_line_out)
		else $error("plain output not low");
	reset_quiet_a: assert property ($fell(sys_rst) |-> irq_n && port_pins_oe == '0)
		else $error("port not quiet after reset");
	timer_irq_a: assert property (timer_flag_set && tmr_keep |-> ##[1:4] (!irq_n || !tmr_keep))
		else $error("enabled timer flag raised no interrupt");
	cover property (rd_st ##1 bus_rdata[7]);
	cover property ($fell(strobe_io_line_out) && strobe_io_line_oe);
	cover property (!irq_n && timer_irq_en);
endmodule : pps_port_chk

bind pps_port pps_port_chk #(.WIDTH(WIDTH)) CHK (.*);

`default_nettype wire

/* File: tb/pps_periph.sv */
// Peripheral model: drives the port pins and both strobe lines.
`timescale 1ns/1ps
`default_nettype none

module pps_periph (
	input wire logic [7:0] drv_val,
	input wire logic [7:0] port_pins_out,
	input wire logic [7:0] port_pins_oe,
	input wire logic l1_lvl,
	input wire logic l2_lvl,
	input wire logic strobe_io_line_out,
	input wire logic strobe_io_line_oe,
	output logic [7:0] port_pins_in,
	output logic strobe_in_line,
	output logic strobe_io_line_in
);
	// Each wire carries the port's drive where enabled, else the peripheral's
	assign port_pins_in = (port_pins_oe & port_pins_out) | (~port_pins_oe & drv_val);
	assign strobe_in_line = l1_lvl;
	assign strobe_io_line_in = strobe_io_line_oe ? strobe_io_line_out : l2_lvl;
endmodule : pps_periph

`default_nettype wire

/* File: tb/pps_port_test.sv */
// Self-checking bench of the parallel port with a peripheral model.
`timescale 1ns/1ps
`default_nettype none

module pps_port_test;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic ext_reset_n = 1'b1;
	logic bus_phase = 1'b0;
	logic bus_sel = 1'b0;
	logic bus_rd = 1'b0;
	logic bus_wr = 1'b0;
	logic [2:0] bus_addr = 3'h0;
	logic [7:0] bus_wdata = 8'h00;
	logic [7:0] bus_rdata;
	logic irq_n;
	logic [7:0] port_pins_in;
	logic [7:0] port_pins_out;
	logic [7:0] port_pins_oe;
	logic strobe_in_line;
	logic strobe_io_line_in;
	logic strobe_io_line_out;
	logic strobe_io_line_oe;
	logic [4:0] tmr_ev = 5'h00; // Set, init, latch write, counter read, soft reset
	logic timer_irq_en = 1'b0;
	logic interval_mode_sel = 1'b0;
	logic [7:0] drv_val = 8'ha5; // Peripheral level on input pins
	logic l1_lvl = 1'b0;
	logic l2_lvl = 1'b0;
	logic [4:0] clr_ev [3] = '{5'h02, 5'h04, 5'h10}; // Events that clear the timer flag
	int error_cnt = 0;
	int check_count = 0;
	wire logic timer_flag_set = tmr_ev[0];
	wire logic timer_counter_init = tmr_ev[1];
	wire logic timer_latch_write = tmr_ev[2];
	wire logic timer_counter_read = tmr_ev[3];
	wire logic timer_soft_reset = tmr_ev[4];

	pps_port DUT (.*);
	pps_periph PERIPH (.*);

	always #5 clk_sys = ~clk_sys;

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	// Count a comparison and report a mismatch at once
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : cmp
	// One bus access, held for exactly the taking edge
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_sel <= 1'b1;
		bus_rd <= !w;
		bus_wr <= w;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk_sys);
		bus_sel <= 1'b0;
		bus_rd <= 1'b0;
		bus_wr <= 1'b0;
		#1;
	endtask : acc
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		cmp(bus_rdata, exp);
	endtask : rd
	task automatic ev(input logic [4:0] m);
		@(posedge clk_sys);
		tmr_ev <= m;
		@(posedge clk_sys);
		tmr_ev <= 5'h00;
		tick(3);
	endtask : ev
	// Move a strobe line and let the synchronisers settle
	task automatic lvl(input logic two, input logic v);
		@(posedge clk_sys);
		if (two) begin
			l2_lvl <= v;
		end else begin
			l1_lvl <= v;
		end
		tick(8);
	endtask : lvl
	task automatic ph();
		@(posedge clk_sys);
		bus_phase <= 1'b1;
		tick(4);
		bus_phase <= 1'b0;
		tick(4);
	endtask : ph
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up

	// Main sequence
	initial begin
		tick(8);
		sys_rst <= 1'b0;
		rd(3'h1, 8'h80);
		rd(3'h0, 8'h00);
		acc(1'b1, 3'h2, 8'hff);
		rd(3'h2, 8'h00);
		acc(1'b1, 3'h1, 8'h00);
		acc(1'b1, 3'h2, 8'h0f);
		rd(3'h2, 8'h0f);
		acc(1'b1, 3'h3, 8'h3c);
		cmp(port_pins_out, 8'h0c);
		rd(3'h3, 8'hac);
		acc(1'b1, 3'h2, 8'hff);
		cmp(port_pins_out, 8'h0c);
		acc(1'b1, 3'h2, 8'h0f);
		// First strobe: falling edge, then enable, then rising edge
		lvl(1'b0, 1'b1);
		rd(3'h0, 8'h00);
		lvl(1'b0, 1'b0);
		rd(3'h0, 8'h02);
		acc(1'b1, 3'h1, 8'h01);
		cmp({7'h00, irq_n}, 8'h00);
		rd(3'h0, 8'h82);
		rd(3'h3, 8'hac);
		rd(3'h0, 8'h00);
		acc(1'b1, 3'h1, 8'h03);
		lvl(1'b0, 1'b1);
		rd(3'h0, 8'h82);
		rd(3'h3, 8'hac);
		lvl(1'b0, 1'b0);
		rd(3'h0, 8'h00);
		// Input latch: a second edge before the read is ignored
		acc(1'b1, 3'h1, 8'h06);
		@(posedge clk_sys);
		drv_val <= 8'h5a;
		lvl(1'b0, 1'b1);
		drv_val <= 8'hc3;
		lvl(1'b0, 1'b0);
		lvl(1'b0, 1'b1);
		rd(3'h3, 8'h5c);
		lvl(1'b0, 1'b0);
		lvl(1'b0, 1'b1);
		rd(3'h3, 8'hcc);
		rd(3'h0, 8'h02);
		acc(1'b1, 3'h3, 8'h00);
		rd(3'h0, 8'h00);
		// Second line as interrupt input, rising edge, enabled
		acc(1'b1, 3'h1, 8'h18);
		lvl(1'b1, 1'b1);
		rd(3'h0, 8'h84);
		rd(3'h3, 8'hc0);
		lvl(1'b1, 1'b0);
		rd(3'h0, 8'h00);
		// Second line as plain output, then handshake, then acknowledge
		acc(1'b1, 3'h1, 8'h38);
		tick(3);
		cmp({6'h00, strobe_io_line_oe, strobe_io_line_out}, 8'h03);
		acc(1'b1, 3'h1, 8'h30);
		tick(3);
		cmp({6'h00, strobe_io_line_oe, strobe_io_line_out}, 8'h02);
		acc(1'b1, 3'h1, 8'h28);
		rd(3'h3, 8'hc0);
		ph();
		cmp({7'h00, strobe_io_line_out}, 8'h00);
		ph();
		cmp({7'h00, strobe_io_line_out}, 8'h01);
		acc(1'b1, 3'h1, 8'h20);
		lvl(1'b0, 1'b0);
		cmp({7'h00, strobe_io_line_out}, 8'h01);
		rd(3'h0, 8'h02);
		rd(3'h3, 8'hc0);
		ph();
		cmp({7'h00, strobe_io_line_out}, 8'h00);
		lvl(1'b0, 1'b1);
		lvl(1'b0, 1'b0);
		cmp({7'h00, strobe_io_line_out}, 8'h01);
		// Port reset bit clears data, direction, flags and latch but keeps the control bits
		acc(1'b1, 3'h1, 8'h84);
		rd(3'h1, 8'h84);
		rd(3'h2, 8'h00);
		rd(3'h0, 8'h00);
		acc(1'b1, 3'h1, 8'h00);
		rd(3'h3, 8'hc3);
		for (int a = 5; a < 8; a++) begin
			rd(a[2:0], 8'h00);
		end
		acc(1'b1, 3'h0, 8'hff);
		rd(3'h0, 8'h00);
		// Timer flag set, gated, and its clear conditions
		ev(5'h01);
		ev(5'h08);
		rd(3'h0, 8'h01);
		rd(3'h4, 8'h01);
		@(posedge clk_sys);
		timer_irq_en <= 1'b1;
		tick(2);
		cmp({7'h00, irq_n}, 8'h00);
		rd(3'h0, 8'h81);
		ev(5'h08);
		rd(3'h0, 8'h00);
		ev(5'h01);
		cmp({7'h00, irq_n}, 8'h00);
		timer_irq_en <= 1'b0;
		ev(5'h04);
		rd(3'h0, 8'h01);
		@(posedge clk_sys);
		interval_mode_sel <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			ev(5'h01);
			ev(clr_ev[k]);
			rd(3'h0, 8'h00);
		end
		// External reset sets the port reset bit and holds it
		ev(5'h01);
		ext_reset_n <= 1'b0;
		tick(8);
		acc(1'b1, 3'h1, 8'h00);
		rd(3'h1, 8'h80);
		rd(3'h0, 8'h00);
		@(posedge clk_sys);
		ext_reset_n <= 1'b1;
		tick(6);
		rd(3'h1, 8'h80);
		acc(1'b1, 3'h1, 8'h00);
		rd(3'h1, 8'h00);
		wrap_up();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end
endmodule : pps_port_test

`default_nettype wire
